/* hw/motor_protection_fault_logger.sv */
// over-torque, thermal relay and fault record logic for motors 3 and 4
// assumes measurement and trip events arrive on clk_sys from drive logic
// Notes on behaviour
// - records are 16-bit; 0 none, 1-3 over-current by state, 6 at stop
// - codes 7-10 over-voltage in four run states, 11-13 low-voltage while running
// - serial command errors log as codes 54 through 58
// - over-torque logs 128/129, thermal trips log 134/135
// - low-voltage at stop is never recorded; while running it is
// - energy backup writes code 62 into every record slot at once
// - selection 0 off, 1-2 constant speed, 3-4 any run; even stops
// - selections 1 and 3 warn and record nothing
// - selections 2 and 4 raise an error and record a fault
// - over-torque level per motor, percent of drive rating, default 120
// - over-torque time per motor in 0.1 s steps, default 0.1 s
// - detect once load stays above level longer than the time
// - continuing warning holds until load drops below 5% of level
// - stopping modes halt the drive until a manual reset
// - thermal type 0 independent fan, 1 shaft fan, 2 off; default 1
// - shaft-fan motors trip sooner at low speed
// - thermal action time per motor 30.0-600.0 s, default 60.0 s
// - thermal threshold is 150% of full-load current; count above it
// - trip once accumulated over-threshold time exceeds action time
// - thermal trip records its code and coasts the motor to stop
// - higher current shortens the effective time to trip
// - thermal accumulation clears on power-up reset
// - a newer fault enters slot 0 and shifts older records down; the oldest drops out
`timescale 1ns/1ps

module motor_protection_fault_logger #(
	parameter int unsigned TICK_CYCLES =
		motor_protection_pkg::TIME_STEP_CYCLES // cycles per 0.1 s
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, power-up
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [motor_protection_pkg::ADR_W-1:0] wb_adr_i, // byte addr
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire motor_protection_pkg::meas_type meas, // drive measurement
	input wire motor_protection_pkg::trip_event_type trip_event, // events
	output motor_protection_pkg::prot_out_type prot_out // actions, log
);
	import motor_protection_pkg::*;

	// helpers
	function automatic logic [15:0] state_code(input logic [15:0] base,
			input logic [15:0] stop_code, input run_state_type st);
		logic [15:0] code;
		code = stop_code;
		case (st)
			RUN_ACCEL: code = base;
			RUN_DECEL: code = base + 16'h0001;
			RUN_CONST: code = base + 16'h0002;
			default: code = stop_code;
		endcase
		return code;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			r[15:8] = dat[15:8];
		end
		return r;
	endfunction

	// bus and configuration state
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [15:0] ot_sel_q [2], ot_sel_d [2];
	logic [15:0] ot_lvl_q [2], ot_lvl_d [2];
	logic [15:0] ot_time_q [2], ot_time_d [2];
	logic [15:0] th_type_q [2], th_type_d [2];
	logic [15:0] th_time_q [2], th_time_d [2];
	logic [15:0] flc_q [2], flc_d [2];
	logic manual_reset;

	// protection state
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	logic [15:0] ot_cnt_q [2], ot_cnt_d [2];
	logic [1:0] warn_q, warn_d;
	logic [1:0] halt_q, halt_d;
	logic [1:0] coast_q, coast_d;
	logic [31:0] th_acc_q [2], th_acc_d [2];
	logic [1:0] ot_fault, th_fault;

	// log state
	logic [15:0] slot_q [NUM_SLOTS], slot_d [NUM_SLOTS];
	logic strobe_q, strobe_d;
	logic [15:0] code_q, code_d;

	logic [IDX_W-1:0] idx;
	logic req;
	assign idx = wb_adr_i[IDX_W+1:2];
	assign req = wb_cyc_i && wb_stb_i && ack_q
		&& wb_adr_i[ADR_W-1:IDX_W+2] == 2'b00;

	// register file, one-wait-state answer, writes land on the ack edge
	always_comb begin
		logic [15:0] rd;
		rd = 16'h0000;
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		dat_d = dat_q;
		manual_reset = 1'b0;
		ot_sel_d = ot_sel_q;
		ot_lvl_d = ot_lvl_q;
		ot_time_d = ot_time_q;
		th_type_d = th_type_q;
		th_time_d = th_time_q;
		flc_d = flc_q;
		if (idx >= IDX_FAULT_SLOT0 && idx <= IDX_FAULT_SLOT3) begin
			rd = slot_q[2'(idx - IDX_FAULT_SLOT0)];
		end else if (idx == IDX_OT_SEL_M3 || idx == IDX_OT_SEL_M4) begin
			rd = ot_sel_q[idx == IDX_OT_SEL_M4];
		end else if (idx == IDX_OT_LVL_M3 || idx == IDX_OT_LVL_M4) begin
			rd = ot_lvl_q[idx == IDX_OT_LVL_M4];
		end else if (idx == IDX_OT_TIME_M3 || idx == IDX_OT_TIME_M4) begin
			rd = ot_time_q[idx == IDX_OT_TIME_M4];
		end else if (idx == IDX_TH_TYPE_M3 || idx == IDX_TH_TYPE_M4) begin
			rd = th_type_q[idx == IDX_TH_TYPE_M4];
		end else if (idx == IDX_TH_TIME_M3 || idx == IDX_TH_TIME_M4) begin
			rd = th_time_q[idx == IDX_TH_TIME_M4];
		end else if (idx == IDX_STATUS) begin
			rd[ST_WARN_LSB +: 2] = warn_q;
			rd[ST_HALT_LSB +: 2] = halt_q;
			rd[ST_COAST_LSB +: 2] = coast_q;
		end else if (idx == IDX_FLC_M3 || idx == IDX_FLC_M4) begin
			rd = flc_q[idx == IDX_FLC_M4];
		end
		if (wb_adr_i[ADR_W-1:IDX_W+2] != 2'b00) begin
			rd = 16'h0000;
		end
		if (ack_d) begin
			dat_d = {16'h0000, rd};
		end
		if (req && wb_we_i) begin
			if (idx == IDX_OT_SEL_M3 || idx == IDX_OT_SEL_M4) begin
				ot_sel_d[idx == IDX_OT_SEL_M4] =
					merge16(ot_sel_q[idx == IDX_OT_SEL_M4], wb_dat_i, wb_sel_i);
			end else if (idx == IDX_OT_LVL_M3 || idx == IDX_OT_LVL_M4) begin
				ot_lvl_d[idx == IDX_OT_LVL_M4] =
					merge16(ot_lvl_q[idx == IDX_OT_LVL_M4], wb_dat_i, wb_sel_i);
			end else if (idx == IDX_OT_TIME_M3 || idx == IDX_OT_TIME_M4) begin
				ot_time_d[idx == IDX_OT_TIME_M4] = merge16(
					ot_time_q[idx == IDX_OT_TIME_M4], wb_dat_i, wb_sel_i);
			end else if (idx == IDX_TH_TYPE_M3 || idx == IDX_TH_TYPE_M4) begin
				th_type_d[idx == IDX_TH_TYPE_M4] = merge16(
					th_type_q[idx == IDX_TH_TYPE_M4], wb_dat_i, wb_sel_i);
			end else if (idx == IDX_TH_TIME_M3 || idx == IDX_TH_TIME_M4) begin
				th_time_d[idx == IDX_TH_TIME_M4] = merge16(
					th_time_q[idx == IDX_TH_TIME_M4], wb_dat_i, wb_sel_i);
			end else if (idx == IDX_CONTROL) begin
				manual_reset = wb_sel_i[0] && wb_dat_i[CTL_MANUAL_RESET];
			end else if (idx == IDX_FLC_M3 || idx == IDX_FLC_M4) begin
				flc_d[idx == IDX_FLC_M4] =
					merge16(flc_q[idx == IDX_FLC_M4], wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			ot_sel_q <= '{OT_SEL_RST, OT_SEL_RST};
			ot_lvl_q <= '{OT_LVL_RST, OT_LVL_RST};
			ot_time_q <= '{OT_TIME_RST, OT_TIME_RST};
			th_type_q <= '{TH_TYPE_RST, TH_TYPE_RST};
			th_time_q <= '{TH_TIME_RST, TH_TIME_RST};
			flc_q <= '{FLC_RST, FLC_RST};
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			ot_sel_q <= ot_sel_d;
			ot_lvl_q <= ot_lvl_d;
			ot_time_q <= ot_time_d;
			th_type_q <= th_type_d;
			th_time_q <= th_time_d;
			flc_q <= flc_d;
		end
	end

	// 0.1 s time base
	always_comb begin
		tick = tick_cnt_q == TICK_CYCLES - 1;
		tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// over-torque and thermal relay, one lane per motor
	always_comb begin
		logic active, enabled, over, detect, th_over;
		logic [31:0] weight, limit, acc_sum;
		active = 1'b0;
		enabled = 1'b0;
		over = 1'b0;
		detect = 1'b0;
		th_over = 1'b0;
		weight = 32'h0000_0000;
		limit = 32'h0000_0000;
		acc_sum = 32'h0000_0000;
		ot_cnt_d = ot_cnt_q;
		th_acc_d = th_acc_q;
		warn_d = warn_q;
		halt_d = halt_q;
		coast_d = coast_q;
		ot_fault = 2'b00;
		th_fault = 2'b00;
		for (int m = 0; m < 2; m++) begin
			active = meas.motor_sel == 1'(m) && meas.state != RUN_STOP;
			enabled = 1'b0;
			if (ot_sel_q[m] == 16'h0001 || ot_sel_q[m] == 16'h0002) begin
				enabled = meas.state == RUN_CONST;
			end else if (ot_sel_q[m] == 16'h0003 || ot_sel_q[m] == OT_SEL_MAX)
					begin
				enabled = 1'b1;
			end
			// selections above OT_SEL_MAX leave enabled low
			over = active && enabled && meas.load_pct > ot_lvl_q[m];
			detect = 1'b0;
			if (!over) begin
				ot_cnt_d[m] = 16'h0000;
			end else if (tick) begin
				detect = ot_cnt_q[m] >= ot_time_q[m];
				if (ot_cnt_q[m] != 16'hFFFF) begin
					ot_cnt_d[m] = ot_cnt_q[m] + 16'h0001;
				end
			end
			if ({16'h0000, meas.load_pct} * 32'(100)
					< {16'h0000, ot_lvl_q[m]} * 32'(OT_RELEASE_PCT)) begin
				warn_d[m] = 1'b0;
			end
			if (manual_reset) begin
				halt_d[m] = 1'b0;
				coast_d[m] = 1'b0;
			end
			if (detect && ot_sel_q[m][0]) begin
				warn_d[m] = 1'b1;
			end
			if (detect && !ot_sel_q[m][0]) begin
				warn_d[m] = 1'b1;
				halt_d[m] = 1'b1;
				ot_fault[m] = !halt_q[m];
			end
			// thermal relay: weight by current, doubled at low fan speed
			th_over = meas.motor_sel == 1'(m)
				&& (th_type_q[m] == TH_TYPE_INDEP || th_type_q[m] == TH_TYPE_FAN)
				&& {16'h0000, meas.current} * 32'(100)
				> {16'h0000, flc_q[m]} * 32'(TH_THR_PCT);
			weight = {16'h0000, meas.current};
			if (th_type_q[m] == TH_TYPE_FAN && meas.speed_pct < LOW_SPEED_PCT)
					begin
				weight = {15'h0000, meas.current, 1'b0};
			end
			limit = 32'({16'h0000, th_time_q[m]} * {16'h0000, flc_q[m]}
				* 32'(TH_THR_PCT) / 32'(100));
			acc_sum = th_acc_q[m] + weight;
			if (th_over && tick) begin
				th_acc_d[m] = acc_sum < th_acc_q[m] ? 32'hFFFF_FFFF : acc_sum;
			end
			if (manual_reset && coast_q[m]) begin
				th_acc_d[m] = 32'h0000_0000;
			end
			if (th_over && tick && th_acc_d[m] > limit && !coast_q[m]) begin
				coast_d[m] = 1'b1;
				th_fault[m] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ot_cnt_q <= '{16'h0000, 16'h0000};
			warn_q <= 2'b00;
			halt_q <= 2'b00;
			coast_q <= 2'b00;
			th_acc_q <= '{32'h0000_0000, 32'h0000_0000};
		end else begin
			ot_cnt_q <= ot_cnt_d;
			warn_q <= warn_d;
			halt_q <= halt_d;
			coast_q <= coast_d;
			th_acc_q <= th_acc_d;
		end
	end

	// fault record encoding and history
	always_comb begin
		logic hit;
		logic [15:0] code;
		hit = 1'b1;
		code = NO_FAULT;
		slot_d = slot_q;
		if (th_fault[0]) begin
			code = FC_TH_M3;
		end else if (th_fault[1]) begin
			code = FC_TH_M3 + 16'h0001;
		end else if (ot_fault[0]) begin
			code = FC_OT_M3;
		end else if (ot_fault[1]) begin
			code = FC_OT_M3 + 16'h0001;
		end else if (trip_event.overcurrent) begin
			code = state_code(FC_OC_ACCEL, FC_OC_STOP, meas.state);
		end else if (trip_event.overvoltage) begin
			code = state_code(FC_OV_ACCEL, FC_OV_ACCEL + 16'h0003,
				meas.state);
		end else if (trip_event.undervoltage && meas.state != RUN_STOP) begin
			code = state_code(FC_UV_ACCEL, FC_UV_STOP, meas.state);
		end else if (trip_event.illegal_command_err) begin
			code = FC_CMD_ERR;
		end else if (trip_event.illegal_address_err) begin
			code = FC_CMD_ERR + 16'h0001;
		end else if (trip_event.illegal_value_err) begin
			code = FC_CMD_ERR + 16'h0002;
		end else if (trip_event.readonly_write_err) begin
			code = FC_CMD_ERR + 16'h0003;
		end else if (trip_event.link_timeout_err) begin
			code = FC_LINK_TIMEOUT;
		end else begin
			hit = 1'b0;
		end
		if (trip_event.decel_energy_backup) begin
			hit = 1'b1;
			code = FC_DEB;
			for (int s = 0; s < NUM_SLOTS; s++) begin
				slot_d[s] = FC_DEB;
			end
		end else if (hit) begin
			for (int s = NUM_SLOTS - 1; s > 0; s--) begin
				slot_d[s] = slot_q[s-1];
			end
			slot_d[0] = code;
		end
		strobe_d = hit;
		code_d = hit ? code : code_q;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slot_q <= '{NO_FAULT, NO_FAULT, NO_FAULT, NO_FAULT};
			strobe_q <= 1'b0;
			code_q <= NO_FAULT;
		end else begin
			slot_q <= slot_d;
			strobe_q <= strobe_d;
			code_q <= code_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign prot_out.overtorque_warn = warn_q;
	assign prot_out.halt = |halt_q;
	assign prot_out.coast = |coast_q;
	assign prot_out.log_strobe = strobe_q;
	assign prot_out.log_code = code_q;

endmodule // motor_protection_fault_logger

/* hw/motor_protection_pkg.sv */
// shared constants and carrier types for the motor 3/4 protection logger
// assumes a 25 MHz system clock and a classic wishbone slave port with 32-bit data and a 16-bit address
package motor_protection_pkg;

	// timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TIME_STEP_MS = 100;
	localparam int unsigned TIME_STEP_CYCLES = CLK_HZ / 1000 * TIME_STEP_MS;

	// bus geometry: register index n sits at byte address 4*n
	localparam int unsigned ADR_W = 16;
	localparam int unsigned IDX_W = 12;

	// register indices
	localparam logic [IDX_W-1:0] IDX_FAULT_SLOT0 = 12'hE46;
	localparam logic [IDX_W-1:0] IDX_FAULT_SLOT3 = 12'hE49;
	localparam logic [IDX_W-1:0] IDX_OT_SEL_M3 = 12'hE4A;
	localparam logic [IDX_W-1:0] IDX_OT_LVL_M3 = 12'hE4B;
	localparam logic [IDX_W-1:0] IDX_OT_TIME_M3 = 12'hE4C;
	localparam logic [IDX_W-1:0] IDX_OT_SEL_M4 = 12'hE4D;
	localparam logic [IDX_W-1:0] IDX_OT_LVL_M4 = 12'hE4E;
	localparam logic [IDX_W-1:0] IDX_OT_TIME_M4 = 12'hE4F;
	localparam logic [IDX_W-1:0] IDX_TH_TYPE_M3 = 12'hE50;
	localparam logic [IDX_W-1:0] IDX_TH_TIME_M3 = 12'hE51;
	localparam logic [IDX_W-1:0] IDX_TH_TYPE_M4 = 12'hE52;
	localparam logic [IDX_W-1:0] IDX_TH_TIME_M4 = 12'hE53;
	localparam logic [IDX_W-1:0] IDX_STATUS = 12'hE54;
	localparam logic [IDX_W-1:0] IDX_CONTROL = 12'hE55;
	localparam logic [IDX_W-1:0] IDX_FLC_M3 = 12'hE56;
	localparam logic [IDX_W-1:0] IDX_FLC_M4 = 12'hE57;

	// reset values
	localparam logic [15:0] OT_SEL_RST = 16'h0000;
	localparam logic [15:0] OT_LVL_RST = 16'h0078;
	localparam logic [15:0] OT_TIME_RST = 16'h0001;
	localparam logic [15:0] TH_TYPE_RST = 16'h0001;
	localparam logic [15:0] TH_TIME_RST = 16'h0258;
	localparam logic [15:0] FLC_RST = 16'h0064;
	localparam logic [15:0] NO_FAULT = 16'h0000;

	// status and control fields
	localparam int unsigned ST_WARN_LSB = 0;
	localparam int unsigned ST_HALT_LSB = 2;
	localparam int unsigned ST_COAST_LSB = 4;
	localparam int unsigned CTL_MANUAL_RESET = 0;

	// fault codes
	localparam logic [15:0] FC_OC_ACCEL = 16'h0001;
	localparam logic [15:0] FC_OC_STOP = 16'h0006;
	localparam logic [15:0] FC_OV_ACCEL = 16'h0007;
	localparam logic [15:0] FC_UV_ACCEL = 16'h000B;
	localparam logic [15:0] FC_UV_STOP = 16'h000E;
	localparam logic [15:0] FC_CMD_ERR = 16'h0036;
	localparam logic [15:0] FC_LINK_TIMEOUT = 16'h003A;
	localparam logic [15:0] FC_DEB = 16'h003E;
	localparam logic [15:0] FC_OT_M3 = 16'h0080;
	localparam logic [15:0] FC_TH_M3 = 16'h0086;

	// selection decode limits and percent figures
	localparam logic [15:0] OT_SEL_MAX = 16'h0004;
	localparam logic [15:0] TH_TYPE_INDEP = 16'h0000;
	localparam logic [15:0] TH_TYPE_FAN = 16'h0001;
	localparam int unsigned TH_THR_PCT = 150;
	localparam int unsigned OT_RELEASE_PCT = 5;
	localparam logic [7:0] LOW_SPEED_PCT = 8'h32;
	localparam int unsigned NUM_SLOTS = 4;

	typedef enum logic [1:0] {
		RUN_STOP,
		RUN_ACCEL,
		RUN_DECEL,
		RUN_CONST
	} run_state_type;

	typedef struct packed {
		run_state_type state;
		logic motor_sel;
		logic [15:0] load_pct;
		logic [15:0] current;
		logic [7:0] speed_pct;
	} meas_type;

	typedef struct packed {
		logic overcurrent;
		logic overvoltage;
		logic undervoltage;
		logic decel_energy_backup;
		logic illegal_command_err;
		logic illegal_address_err;
		logic illegal_value_err;
		logic readonly_write_err;
		logic link_timeout_err;
	} trip_event_type;

	typedef struct packed {
		logic [1:0] overtorque_warn;
		logic halt;
		logic coast;
		logic log_strobe;
		logic [15:0] log_code;
	} prot_out_type;

endpackage

/* verif/drive_side_model.sv */
// drive side model: run state, load, current, speed and event pulses
// assumes the bench sets its requests just after a rising clk_sys edge
`timescale 1ns/1ps
module drive_side_model (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset
	input wire motor_protection_pkg::meas_type meas_set, // wanted levels
	input wire logic [8:0] ev_req, // event request, one cycle
	output motor_protection_pkg::meas_type meas, // to the block
	output motor_protection_pkg::trip_event_type trip_event // to the block
);
	import motor_protection_pkg::*;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meas <= '0;
			trip_event <= '0;
		end else begin
			meas <= meas_set;
			trip_event <= trip_event_type'(ev_req);
		end
	end
endmodule // drive_side_model

/* verif/motor_protection_fault_logger_assertions.sv */
// checker on the ports of the protection logger
// assumes it is bound to the top module, one clock, async low reset
`timescale 1ns/1ps
module motor_protection_fault_logger_assertions (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [motor_protection_pkg::ADR_W-1:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // acknowledge
	input wire motor_protection_pkg::meas_type meas, // measurement
	input wire motor_protection_pkg::trip_event_type trip_event, // events
	input wire motor_protection_pkg::prot_out_type prot_out // actions
);
	import motor_protection_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic ctl_wr;
	assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
		wb_sel_i[0] && wb_dat_i[0] &&
		wb_adr_i == {2'b00, IDX_CONTROL, 2'b00};
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_oc_accel;
		trip_event.overcurrent && !trip_event.decel_energy_backup &&
			meas.state == RUN_ACCEL;
	endsequence
	sequence s_ot_log;
		prot_out.log_strobe && (prot_out.log_code == FC_OT_M3 ||
			prot_out.log_code == FC_OT_M3 + 16'h0001);
	endsequence
	property p_ack_latency;
		s_take |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
	endproperty
	property p_oc_accel;
		s_oc_accel |=> prot_out.log_strobe &&
			(prot_out.log_code == FC_OC_ACCEL || prot_out.log_code >= FC_OT_M3);
	endproperty
	property p_uv_stop;
		trip_event == 9'h040 && meas.state == RUN_STOP |=>
			!prot_out.log_strobe || prot_out.log_code >= FC_OT_M3;
	endproperty
	property p_deb;
		trip_event.decel_energy_backup |=>
			prot_out.log_strobe && prot_out.log_code == FC_DEB;
	endproperty
	property p_halt_log;
		$rose(prot_out.halt) |-> ##[0:1] s_ot_log;
	endproperty
	property p_halt_hold;
		prot_out.halt && !ctl_wr |=> prot_out.halt;
	endproperty
	property p_coast_hold;
		prot_out.coast && !ctl_wr |=> prot_out.coast;
	endproperty
	a_ack_latency: assert property (p_ack_latency)
		else $error("ack missing after request");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_dat_hi: assert property (p_dat_hi)
		else $error("upper read data not zero");
	a_oc_accel: assert property (p_oc_accel)
		else $error("over-current while accelerating not logged as 1");
	a_uv_stop: assert property (p_uv_stop)
		else $error("low voltage at stop logged");
	a_deb: assert property (p_deb)
		else $error("energy backup not logged as 62");
	a_halt_log: assert property (p_halt_log)
		else $error("halt without over-torque record");
	a_halt_hold: assert property (p_halt_hold)
		else $error("halt dropped without manual reset");
	a_coast_hold: assert property (p_coast_hold)
		else $error("coast dropped without manual reset");
endmodule // motor_protection_fault_logger_assertions

/* verif/tb_motor_protection_fault_logger.sv */
// self-checking bench for the protection logger over classic wishbone
// assumes the drive side model and the checker are compiled before it
`timescale 1ns/1ps
module tb_motor_protection_fault_logger;
	import motor_protection_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [15:0] wb_adr = 16'h0000;
	logic [3:0] wb_sel = 4'h3;
	logic [3:0] sel_next = 4'h3;
	logic [31:0] wb_dat = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	meas_type meas_set = '0;
	logic [8:0] ev_req = 9'h000;
	meas_type meas;
	trip_event_type trip_event;
	prot_out_type prot_out;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] rd;
	logic [15:0] last;
	logic [11:0] didx [9] = '{IDX_OT_SEL_M3, IDX_OT_LVL_M3, IDX_OT_TIME_M3,
		IDX_OT_LVL_M4, IDX_TH_TYPE_M3, IDX_TH_TIME_M4, IDX_FAULT_SLOT3,
		IDX_FLC_M4, 12'hE60};
	logic [15:0] dexp [9] = '{OT_SEL_RST, OT_LVL_RST, OT_TIME_RST, OT_LVL_RST,
		TH_TYPE_RST, TH_TIME_RST, NO_FAULT, FLC_RST, 16'h0000};
	logic [15:0] base [3] = '{FC_OC_ACCEL, FC_OV_ACCEL, FC_UV_ACCEL};
	logic [15:0] ot_st [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001,
		16'h0005, 16'h0000};
	logic [15:0] th_cu [3] = '{16'h00A0, 16'h00A0, 16'h0140};
	logic [15:0] th_at [3] = '{16'h0000, 16'h0010, 16'h0010};

	motor_protection_fault_logger #(.TICK_CYCLES(10)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.meas(meas), .trip_event(trip_event), .prot_out(prot_out));
	drive_side_model drive_u (.clk_sys(clk_sys), .rstn(rstn),
		.meas_set(meas_set), .ev_req(ev_req), .meas(meas),
		.trip_event(trip_event));

	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 20000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (fail_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic we, input logic [11:0] idx,
		input logic [15:0] wd);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= sel_next;
		wb_adr <= {2'b00, idx, 2'b00};
		wb_dat <= {16'h0000, wd};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[15:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] idx, input logic [15:0] exp);
		wb(1'b0, idx, 16'h0000);
		chk(rd, exp);
	endtask
	task automatic drive(input run_state_type st, input logic m,
		input logic [15:0] load, input logic [15:0] cur, input logic [7:0] sp);
		@(posedge clk_sys);
		meas_set <= '{state: st, motor_sel: m, load_pct: load, current: cur,
			speed_pct: sp};
	endtask
	task automatic log_chk(input logic [8:0] ev, input run_state_type st,
		input logic [15:0] exp, input logic logd);
		@(posedge clk_sys);
		meas_set.state <= st;
		ev_req <= ev;
		@(posedge clk_sys);
		ev_req <= 9'h000;
		ticks(2);
		chk(prot_out.log_code, logd ? exp : last);
		rchk(IDX_FAULT_SLOT0, logd ? exp : last);
		if (logd) begin
			rchk(IDX_FAULT_SLOT0 + 12'h001, last);
			last = exp;
		end
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		ticks(6);
		rstn <= 1'b1;
		last = NO_FAULT;
	endtask

	initial begin
		do_reset();
		for (int i = 0; i < 9; i++) begin
			rchk(didx[i], dexp[i]);
		end
		wb(1'b1, IDX_OT_LVL_M4, 16'hA5C3);
		rchk(IDX_OT_LVL_M4, 16'hA5C3);
		sel_next = 4'h2;
		wb(1'b1, IDX_OT_LVL_M4, 16'h5A00);
		sel_next = 4'h3;
		rchk(IDX_OT_LVL_M4, 16'h5AC3);
		wb(1'b1, IDX_OT_LVL_M4, OT_LVL_RST);
		wb(1'b1, IDX_FAULT_SLOT0, 16'h1234);
		rchk(IDX_FAULT_SLOT0, NO_FAULT);
		for (int k = 0; k < 3; k++) begin
			for (int s = 0; s < 4; s++) begin
				log_chk(9'h100 >> k, run_state_type'((s + 1) % 4),
					s < 3 ? base[k] + 16'(s) :
					(k == 0 ? FC_OC_STOP : base[k] + 16'h0003),
					!(k == 2 && s == 3));
			end
		end
		for (int j = 0; j < 5; j++) begin
			log_chk(9'h010 >> j, RUN_CONST, FC_CMD_ERR + 16'(j), 1'b1);
		end
		last = FC_DEB;
		log_chk(9'h020, RUN_CONST, FC_DEB, 1'b1);
		for (int i = 0; i < 4; i++) begin
			rchk(IDX_FAULT_SLOT0 + 12'(i), FC_DEB);
		end
		wb(1'b1, IDX_OT_TIME_M3, 16'h0002);
		for (int m = 0; m < 6; m++) begin
			wb(1'b1, IDX_OT_SEL_M3, 16'(m));
			drive(RUN_ACCEL, 1'b0, 16'h0082, 16'h0000, 8'h64);
			ticks(60);
			rchk(IDX_STATUS, ot_st[m]);
			if (m == 4) begin
				last = FC_OT_M3;
			end
			rchk(IDX_FAULT_SLOT0, last);
			drive(RUN_STOP, 1'b0, 16'h0000, 16'h0000, 8'h00);
			ticks(30);
			wb(1'b0, IDX_STATUS, 16'h0000);
			chk(rd & 16'h000C, m == 4 ? 16'h0004 : 16'h0000);
			chk({15'h0000, prot_out.halt}, 16'(m == 4));
			wb(1'b1, IDX_CONTROL, 16'h0001);
			rchk(IDX_STATUS, 16'h0000);
		end
		wb(1'b1, IDX_OT_SEL_M3, 16'h0001);
		drive(RUN_CONST, 1'b0, 16'h0082, 16'h0000, 8'h64);
		ticks(5);
		drive(RUN_CONST, 1'b0, 16'h0064, 16'h0000, 8'h64);
		ticks(40);
		rchk(IDX_STATUS, 16'h0000);
		drive(RUN_CONST, 1'b0, 16'h0082, 16'h0000, 8'h64);
		ticks(40);
		drive(RUN_CONST, 1'b0, 16'h000A, 16'h0000, 8'h64);
		ticks(30);
		rchk(IDX_STATUS, 16'h0001);
		chk({14'h0000, prot_out.overtorque_warn}, 16'h0001);
		drive(RUN_CONST, 1'b0, 16'h0005, 16'h0000, 8'h64);
		ticks(30);
		rchk(IDX_STATUS, 16'h0000);
		wb(1'b1, IDX_OT_SEL_M4, 16'h0004);
		drive(RUN_ACCEL, 1'b1, 16'h0082, 16'h0000, 8'h64);
		ticks(60);
		rchk(IDX_STATUS, 16'h000A);
		rchk(IDX_FAULT_SLOT0, FC_OT_M3 + 16'h0001);
		drive(RUN_STOP, 1'b0, 16'h0000, 16'h0000, 8'h00);
		wb(1'b1, IDX_CONTROL, 16'h0001);
		wb(1'b1, IDX_TH_TIME_M3, 16'h0006);
		for (int c = 0; c < 3; c++) begin
			wb(1'b1, IDX_TH_TYPE_M3, c == 1 ? TH_TYPE_FAN : TH_TYPE_INDEP);
			drive(RUN_CONST, 1'b0, 16'h0000, th_cu[c], c < 2 ? 8'h14 : 8'h50);
			ticks(45);
			rchk(IDX_STATUS, th_at[c]);
			ticks(40);
			rchk(IDX_STATUS, 16'h0010);
			chk({15'h0000, prot_out.coast}, 16'h0001);
			rchk(IDX_FAULT_SLOT0, FC_TH_M3);
			drive(RUN_STOP, 1'b0, 16'h0000, 16'h0000, 8'h00);
			wb(1'b1, IDX_CONTROL, 16'h0001);
		end
		for (int t = 2; t < 4; t++) begin
			wb(1'b1, IDX_TH_TYPE_M3, 16'(t));
			drive(RUN_CONST, 1'b0, 16'h0000, 16'h0140, 8'h50);
			ticks(60);
			rchk(IDX_STATUS, 16'h0000);
		end
		wb(1'b1, IDX_TH_TYPE_M3, TH_TYPE_INDEP);
		drive(RUN_CONST, 1'b0, 16'h0000, 16'h00A0, 8'h50);
		ticks(30);
		do_reset();
		rchk(IDX_FAULT_SLOT0, NO_FAULT);
		wb(1'b1, IDX_TH_TIME_M3, 16'h0006);
		wb(1'b1, IDX_TH_TYPE_M3, TH_TYPE_INDEP);
		ticks(30);
		rchk(IDX_STATUS, 16'h0000);
		end_sim();
	end
endmodule // tb_motor_protection_fault_logger

bind motor_protection_fault_logger motor_protection_fault_logger_assertions
	chk_u (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .meas(meas), .trip_event(trip_event),
	.prot_out(prot_out));
